// [spd_shift.sv]
// Purpose: Constants for the serial data path and its byte shift engine
// Assumes: One clock; link pins sampled through three flip-flops
// Notes:   Engine runs mode 0 (idle low, sample on rising edge)
package spd_pkg;
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_CSR    = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT  = 8'h10;
  // Status bit positions, shared by csr, event status and mask
  localparam int BIT_DONE = 7;
  localparam int BIT_WRITE_COLLISION_FLAG = 6;
  localparam int BIT_OVR  = 5;
  // Control fields
  localparam int BIT_EN     = 0;
  localparam int BIT_MASTER = 1;
  localparam int DIV_LSB    = 8;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  // Sync order {ss_n, miso, mosi, sck}; select idles high
  localparam logic [3:0]  SYNC_RST  = 4'h8;
  typedef enum logic [1:0] {
    SPD_IDLE = 2'b00,
    SPD_RUN  = 2'b01
  } spd_state_e;
endpackage

module spd_shift #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control from register side
  input  wire logic             start,
  input  wire logic             master,
  input  wire logic             enable,
  input  wire logic [7:0]       tx_byte,
  input  wire logic [DIV_W-1:0] half_div,
  // Status to register side
  output logic                  busy,
  output logic                  done_pulse,
  output logic [7:0]            rx_byte,
  // Link pins
  input  wire logic             sck_i,
  input  wire logic             mosi_i,
  input  wire logic             miso_i,
  input  wire logic             ss_n_i,
  output logic                  sck_o,
  output logic                  sck_oe,
  output logic                  mosi_o,
  output logic                  mosi_oe,
  output logic                  miso_o,
  output logic                  miso_oe
);
  import spd_pkg::*;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("spd_shift: DIV_W must be 1 to 16");
  end

  logic [3:0]       s1_r, s2_r, s3_r, filt_r, filt_d_r;
  logic [3:0]       agree;
  spd_state_e       state_r;
  logic [2:0]       cnt_r;
  logic [7:0]       sh_r;
  logic             rxbit_r;
  logic [DIV_W-1:0] div_r;
  logic             tick, sck_rise, sck_fall, ss_act;

  // Change counts once stages two and three agree
  assign agree    = ~(s2_r ^ s3_r);
  assign sck_rise = filt_r[0] & ~filt_d_r[0];
  assign sck_fall = ~filt_r[0] & filt_d_r[0];
  assign ss_act   = ~filt_r[3];
  assign busy     = (state_r == SPD_RUN);
  assign tick     = (div_r == half_div);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r     <= SYNC_RST;
      s2_r     <= SYNC_RST;
      s3_r     <= SYNC_RST;
      filt_r   <= SYNC_RST;
      filt_d_r <= SYNC_RST;
    end else begin
      s1_r     <= {ss_n_i, miso_i, mosi_i, sck_i};
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      filt_r   <= (agree & s2_r) | (~agree & filt_r);
      filt_d_r <= filt_r;
    end
  end

  // Half-period divider, only while a master byte runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (!busy || !master || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= SPD_IDLE;
      cnt_r      <= '0;
      sh_r       <= '0;
      rxbit_r    <= 1'b0;
      rx_byte    <= '0;
      done_pulse <= 1'b0;
      sck_o      <= 1'b0;
      mosi_o     <= 1'b0;
      miso_o     <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      case (state_r)
        SPD_IDLE: begin
          sck_o <= 1'b0;
          cnt_r <= '0;
          if (start) begin
            // Byte goes straight into the shifter, no staging
            sh_r <= tx_byte;
            if (master) begin
              mosi_o  <= tx_byte[7];
              state_r <= SPD_RUN;
            end else begin
              miso_o <= tx_byte[7];
            end
          end else if (enable && !master && ss_act) begin
            state_r <= SPD_RUN;
          end
        end
        SPD_RUN: begin
          if (!enable) begin
            state_r <= SPD_IDLE;
          end else if (master) begin
            if (tick && !sck_o) begin
              sck_o   <= 1'b1;
              rxbit_r <= filt_r[2];
            end else if (tick) begin
              sck_o  <= 1'b0;
              sh_r   <= {sh_r[6:0], rxbit_r};
              mosi_o <= sh_r[6];
              cnt_r  <= cnt_r + 3'h1;
              if (cnt_r == LAST_BIT) begin
                rx_byte    <= {sh_r[6:0], rxbit_r};
                done_pulse <= 1'b1;
                state_r    <= SPD_IDLE;
              end
            end
          end else if (!ss_act) begin
            // Partial slave byte is dropped on deselect
            state_r <= SPD_IDLE;
          end else if (sck_rise) begin
            rxbit_r <= filt_r[1];
          end else if (sck_fall) begin
            sh_r   <= {sh_r[6:0], rxbit_r};
            miso_o <= sh_r[6];
            cnt_r  <= cnt_r + 3'h1;
            if (cnt_r == LAST_BIT) begin
              rx_byte    <= {sh_r[6:0], rxbit_r};
              done_pulse <= 1'b1;
            end
          end
        end
        default: state_r <= SPD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_oe  <= enable & master;
      mosi_oe <= enable & master;
      miso_oe <= enable & ~master & ss_act;
    end
  end
endmodule

// [spd_top.sv]
// Purpose: Serial data register path with APB slave and interrupt
// Assumes: pclk 125 MHz; link pins asynchronous to pclk
// Notes:   Receive buffer has no reset; reads before a transfer are undefined
// Summary of operation
// - In master mode a write to the data register starts one byte transfer.
// - At transfer completion the received byte is copied to a receive buffer if the done flag is clear.
// - Reading the data register returns the receive buffer, not the shifter.
// - While the done flag is set, data writes are ignored until csr is read or written.
// - An accepted data write loads the shifter directly, with no buffer.
// - The data register is eight bits, read/write, undefined after reset.
// - The done flag clears after a csr access followed by a data access.
// - A byte completing while the done flag is set raises overrun.
// - A data write during a running transfer raises write collision.
module spd_top #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Link pins
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i
);
  import spd_pkg::*;

  logic [31:0]      ctrl_r;
  logic [7:0]       mask_r, istat_r, istat_nxt, csr_rd;
  logic [7:0]       rxbuf_r;
  logic             done_r, write_collision_flag_r, ovr_r, armed_r;
  logic             busy, done_pulse;
  logic [7:0]       rx_byte;
  logic             acc, wr_data, rd_data, acc_csr, rd_csr;
  logic             wr_ok, start, write_collision_flag_ev, ovr_ev;
  logic             seq_clear;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // Access takes effect at the edge pready is seen high
  assign acc     = psel & penable & pready;
  assign wr_data = acc & pwrite & hit(paddr, ADDR_DATA);
  assign rd_data = acc & ~pwrite & hit(paddr, ADDR_DATA);
  assign acc_csr = acc & hit(paddr, ADDR_CSR);
  assign rd_csr  = acc_csr & ~pwrite;
  assign wr_ok   = wr_data & ctrl_r[BIT_EN] & ~busy & ~(done_r & ~armed_r);
  assign start   = wr_ok;
  assign write_collision_flag_ev = wr_data & busy;
  assign ovr_ev  = done_pulse & done_r;
  assign seq_clear = armed_r & (wr_data | rd_data);
  assign csr_rd  = {done_r, write_collision_flag_r, ovr_r, 5'h00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        prdata <= '0;
        case (paddr)
          ADDR_DATA:  prdata <= {24'h00_0000, rxbuf_r};
          ADDR_CSR:   prdata <= {24'h00_0000, csr_rd};
          ADDR_CTRL:  prdata <= ctrl_r;
          ADDR_MASK:  prdata <= {24'h00_0000, mask_r};
          ADDR_ISTAT: prdata <= {24'h00_0000, istat_r};
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end else if (acc & pwrite) begin
      if (hit(paddr, ADDR_CTRL)) begin
        ctrl_r <= {16'h0000, pwdata[15:0]};
      end
      if (hit(paddr, ADDR_MASK)) begin
        mask_r <= pwdata[7:0] & csr_mask();
      end
    end
  end

  function automatic logic [7:0] csr_mask();
    logic [7:0] m;
    m = '0;
    m[BIT_DONE] = 1'b1;
    m[BIT_WRITE_COLLISION_FLAG] = 1'b1;
    m[BIT_OVR]  = 1'b1;
    return m;
  endfunction

  always_ff @(posedge pclk) begin
    if (done_pulse && !done_r) begin
      rxbuf_r <= rx_byte;
    end
  end

  // Set wins over clear on every flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r  <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      ovr_r   <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (done_pulse) begin
        done_r <= 1'b1;
      end else if (seq_clear) begin
        done_r <= 1'b0;
      end
      if (write_collision_flag_ev) begin
        write_collision_flag_r <= 1'b1;
      end else if (seq_clear) begin
        write_collision_flag_r <= 1'b0;
      end
      if (ovr_ev) begin
        ovr_r <= 1'b1;
      end else if (rd_csr) begin
        ovr_r <= 1'b0;
      end
      if (acc_csr) begin
        armed_r <= 1'b1;
      end else if (seq_clear || done_pulse) begin
        armed_r <= 1'b0;
      end
    end
  end

  always_comb begin
    istat_nxt = istat_r;
    if (acc & pwrite & hit(paddr, ADDR_ISTAT)) begin
      istat_nxt = istat_r & ~pwdata[7:0];
    end
    istat_nxt[BIT_DONE] = istat_nxt[BIT_DONE] | done_pulse;
    istat_nxt[BIT_WRITE_COLLISION_FLAG] = istat_nxt[BIT_WRITE_COLLISION_FLAG] | write_collision_flag_ev;
    istat_nxt[BIT_OVR]  = istat_nxt[BIT_OVR] | ovr_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= '0;
      irq     <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq     <= |(istat_nxt & mask_r);
    end
  end

  spd_shift #(
    .DIV_W (DIV_W)
  ) u_shift (
    .clk        (pclk),
    .rst_n      (presetn),
    .start      (start),
    .master     (ctrl_r[BIT_MASTER]),
    .enable     (ctrl_r[BIT_EN]),
    .tx_byte    (pwdata[7:0]),
    .half_div   (ctrl_r[DIV_LSB +: DIV_W]),
    .busy       (busy),
    .done_pulse (done_pulse),
    .rx_byte    (rx_byte),
    .sck_i      (sck_i),
    .mosi_i     (mosi_i),
    .miso_i     (miso_i),
    .ss_n_i     (ss_n_i),
    .sck_o      (sck_o),
    .sck_oe     (sck_oe),
    .mosi_o     (mosi_o),
    .mosi_oe    (mosi_oe),
    .miso_o     (miso_o),
    .miso_oe    (miso_oe)
  );
endmodule

// [spd_peer.sv]
// Purpose: Behavioural serial peripheral on the master link
// Assumes: Mode 0, MSB first, always selected
// Notes:   Reloads its reply byte after every eighth bit
module spd_peer (
  // Link
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Test side
  input  wire logic [7:0] tx,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] so;
  int         n = 0;
  always @(posedge sck) begin
    rx = {rx[6:0], mosi};
    n = (n + 1) % 8;
  end
  // Filler bits toggle so stale data never looks valid
  always @(negedge sck) begin
    so = (n == 0) ? tx : {so[6:0], ~so[0]};
  end
  always @(tx) begin
    if (n == 0) begin
      so = tx;
    end
  end
  assign miso = so[7];
endmodule

// [spd_top_chk.sv]
// Purpose: Port checks for the serial data path
// Assumes: Divider field kept at 4 while in master mode
// Notes:   Bound to every spd_top instance
module spd_top_chk
  import spd_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq,
  // Link
  input wire logic        sck_o,
  input wire logic        sck_oe,
  input wire logic        mosi_o,
  input wire logic        mosi_oe,
  input wire logic        miso_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy)
    else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one)
    else $error("ready held too long");
  property p_err; pslverr |-> pready && prdata == 0; endproperty
  a_err: assert property (p_err)
    else $error("bad error response");
  property p_dhi;
    pready && !pwrite && paddr == ADDR_DATA |-> prdata[31:8] == 0;
  endproperty
  a_dhi: assert property (p_dhi)
    else $error("data read upper bits set");
  property p_half; $rose(sck_o) |-> sck_o[*5] ##1 !sck_o; endproperty
  a_half: assert property (p_half)
    else $error("clock half period wrong");
  property p_mosi; $changed(mosi_o) |-> !sck_o; endproperty
  a_mosi: assert property (p_mosi)
    else $error("data changed with clock high");
  property p_oe; sck_oe |-> mosi_oe && !miso_oe; endproperty
  a_oe: assert property (p_oe)
    else $error("enables disagree");
  property p_sck; $changed(sck_o) |-> sck_oe; endproperty
  a_sck: assert property (p_sck)
    else $error("clock moved undriven");
  c_sck: cover property ($rose(sck_o));
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_slv: cover property (miso_oe);
endmodule
bind spd_top spd_top_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pready, .prdata, .pslverr, .irq, .sck_o, .sck_oe,
  .mosi_o, .mosi_oe, .miso_oe);

// [testbench.sv]
// Purpose: Self-checking bench for the serial data path
// Assumes: Master divider 4; slave clock 160 ns
// Notes:   Only wirq waits are bounded; an apb hang ends in stop_test via the watchdog
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import spd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, p_tx, p_rx;
  logic [31:0] pwdata, prdata, rd;
  logic        irq, err, sck_i, sck_o, sck_oe, mosi_i, mosi_o, mosi_oe;
  logic        miso_i, miso_o, miso_oe, ss_n_i;
  int          num_errors = 0;
  int          checks = 0;
  spd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .irq, .sck_i, .sck_o, .sck_oe,
    .mosi_i, .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i);
  spd_peer PEER (.sck(sck_o), .mosi(mosi_o), .miso(miso_i), .tx(p_tx),
    .rx(p_rx));
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] e);
    checks++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, got);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait count; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    apb(0, a, '0);
    chk($sformatf("reg%h", a), rd, e);
  endtask
  task automatic irqchk(logic e);
    @(posedge pclk);
    chk("irq", irq, e);
  endtask
  task automatic wirq;
    int n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk("irq", irq, 1);
  endtask
  task automatic sbyte(logic [7:0] b, output logic [7:0] got);
    ss_n_i <= 0;
    repeat (10) @(posedge pclk);
    chk("miso_oe", miso_oe, 1);
    for (int i = 7; i >= 0; i--) begin
      mosi_i <= b[i];
      repeat (10) @(posedge pclk);
      sck_i <= 1;
      got[i] = miso_o;
      repeat (10) @(posedge pclk);
      sck_i <= 0;
    end
    repeat (10) @(posedge pclk);
    ss_n_i <= 1;
    mosi_i <= ~mosi_i;
    repeat (10) @(posedge pclk);
    chk("miso_oe", miso_oe, 0);
  endtask
  task automatic t_regs;
    rdc(ADDR_CTRL, CTRL_RST);
    rdc(ADDR_MASK, {24'h00_0000, MASK_RST});
    apb(0, 8'h20, 32'h0000_0000);
    chk("slverr", err, 1);
  endtask
  task automatic t_slave;
    logic [7:0] g;
    apb(1, ADDR_CTRL, 32'h0000_0001);
    apb(1, ADDR_DATA, 32'h0000_00C3);
    sbyte(8'h96, g);
    chk("miso", g, 8'hC3);
    sbyte(8'h0F, g);
    rdc(ADDR_CSR, 32'h0000_00A0);
    chk("irq", irq, 0);
    rdc(ADDR_DATA, 32'h0000_0096);
    rdc(ADDR_CSR, 32'h0000_0000);
    apb(1, ADDR_MASK, 32'h0000_0080);
    irqchk(1);
    apb(1, ADDR_ISTAT, 32'h0000_00E0);
    irqchk(0);
  endtask
  task automatic t_master;
    apb(1, ADDR_CTRL, 32'h0000_0403);
    p_tx = 8'hA5;
    apb(1, ADDR_DATA, 32'h0000_003C);
    wirq;
    chk("peer", p_rx, 8'h3C);
    chk("sck_oe", sck_oe, 1);
    chk("mosi_oe", mosi_oe, 1);
    chk("miso_oe", miso_oe, 0);
    apb(1, ADDR_DATA, 32'h0000_0011);
    // Long enough for a whole byte had the write got through
    repeat (100) @(posedge pclk);
    chk("sck", sck_o, 0);
    chk("peer", p_rx, 8'h3C);
    rdc(ADDR_CSR, 32'h0000_0080);
    apb(1, ADDR_ISTAT, 32'h0000_0080);
    irqchk(0);
    p_tx = 8'h5A;
    apb(1, ADDR_DATA, 32'h0000_0077);
    apb(1, ADDR_DATA, 32'h0000_00FF);
    rdc(ADDR_DATA, 32'h0000_00A5);
    wirq;
    chk("peer", p_rx, 8'h77);
    rdc(ADDR_CSR, 32'h0000_00C0);
    rdc(ADDR_DATA, 32'h0000_005A);
    rdc(ADDR_CSR, 32'h0000_0000);
  endtask
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    sck_i = 0;
    mosi_i = 0;
    ss_n_i = 1;
    p_tx = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_slave;
    t_master;
    stop_test;
  end
endmodule
